//--- src/hrp_device.sv
// device end: read code latch, byte mux and status byte
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ns
module hrp_device (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // host bus
    hrp_if.device bus,
    // data sources from the core
    input wire logic [15:0] i_in,
    input wire logic [15:0] q_in,
    input wire logic [15:0] mag_in,
    input wire logic [15:0] phase_in,
    input wire logic [15:0] freq_in,
    input wire logic [23:0] level_in,
    input wire logic [14:0] gain_in,       // [14:11] shift, [10:0] mantissa
    input wire logic [15:0] timing_err_in,
    // status sources
    input wire logic [2:0] fifo_depth_in,
    input wire logic fifo_empty_in,
    input wire logic fifo_full_in,
    input wire logic buffer_ready_n_in,
    input wire logic integ_done_in,
    // gain sample strobe out to the core
    output logic gain_sample_out
);
    // ----------------------------------------
    // write strobe edge
    // ----------------------------------------
    logic wr_n_q;
    logic [2:0] code_q;
    logic [2:0] wr_addr_q;
    logic [2:0] wr_data_q;
    logic [14:0] gain_q;       // gain held at sample time
    logic [7:0] byte_d;
    logic [7:0] status;
    logic wr_rise;

    // address and data captured while strobe is low, used at its rise
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            wr_n_q <= 1'b1;
            wr_addr_q <= 3'h0;
            wr_data_q <= 3'h0;
        end else begin
            wr_n_q <= bus.wr_n;
            if (!bus.wr_n) begin
                wr_addr_q <= bus.addr;
                wr_data_q <= bus.host_data[2:0];
            end
        end
    end

    assign wr_rise = bus.wr_n && !wr_n_q;

    // read code latch
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            code_q <= hrp_pkg::CODE_RESET;
        end else if (wr_rise && wr_addr_q == hrp_pkg::ADDR_READ_SOURCE_SELECT) begin
            code_q <= wr_data_q; // RULE2
        end
    end

    // gain snapshot, so both bytes are coherent
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            gain_q <= 15'h0000;
            gain_sample_out <= 1'b0;
        end else begin
            gain_sample_out <= wr_rise && wr_addr_q == hrp_pkg::ADDR_GAIN_SAMPLE;
            if (wr_rise && wr_addr_q == hrp_pkg::ADDR_GAIN_SAMPLE) begin
                gain_q <= gain_in; // RULE11
            end
        end
    end

    // ----------------------------------------
    // status byte
    // ----------------------------------------
    always_comb begin
        status = 8'h00;
        status[hrp_pkg::STAT_DEPTH_LSB +: 3] = fifo_depth_in; // RULE13
        status[hrp_pkg::STAT_EMPTY_BIT] = fifo_empty_in;      // RULE14
        status[hrp_pkg::STAT_FULL_BIT] = fifo_full_in;        // RULE15
        status[hrp_pkg::STAT_READY_N_BIT] = buffer_ready_n_in; // RULE16
        status[hrp_pkg::STAT_INTEG_BIT] = integ_done_in;      // RULE17
    end

    // ----------------------------------------
    // byte selection
    // ----------------------------------------
    always_comb begin
        byte_d = 8'h00; // RULE19
        if (bus.addr == hrp_pkg::ADDR_STATUS_BYTE) begin
            byte_d = status; // RULE5
        end else begin
            case (code_q) // RULE3
                hrp_pkg::CODE_IQ: begin // RULE6
                    case (bus.addr)
                        3'h0: byte_d = i_in[7:0];
                        3'h1: byte_d = i_in[15:8];
                        3'h2: byte_d = q_in[7:0];
                        3'h3: byte_d = q_in[15:8];
                        default: byte_d = 8'h00;
                    endcase
                end
                hrp_pkg::CODE_MAG_PHASE: begin // RULE7
                    case (bus.addr)
                        3'h0: byte_d = mag_in[7:0];
                        3'h1: byte_d = mag_in[15:8];
                        3'h2: byte_d = phase_in[7:0];
                        3'h3: byte_d = phase_in[15:8];
                        default: byte_d = 8'h00;
                    endcase
                end
                hrp_pkg::CODE_FREQ: begin // RULE8
                    case (bus.addr)
                        3'h0: byte_d = freq_in[7:0];
                        3'h1: byte_d = freq_in[15:8];
                        default: byte_d = 8'h00;
                    endcase
                end
                hrp_pkg::CODE_LEVEL: begin // RULE9
                    case (bus.addr)
                        3'h0: byte_d = level_in[7:0];
                        3'h1: byte_d = level_in[15:8];
                        3'h2: byte_d = level_in[23:16];
                        default: byte_d = 8'h00;
                    endcase
                end
                hrp_pkg::CODE_GAIN_TE: begin
                    case (bus.addr)
                        3'h0: byte_d = gain_q[7:0];                    // RULE10
                        3'h1: byte_d = {1'b0, gain_q[14:8]};           // RULE10
                        3'h2: byte_d = timing_err_in[7:0];             // RULE12
                        3'h3: byte_d = timing_err_in[15:8];            // RULE12
                        default: byte_d = 8'h00;
                    endcase
                end
                default: byte_d = 8'h00; // RULE19
            endcase
        end
    end

    // ----------------------------------------
    // data bus drive, registered one clock after strobe falls
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            bus.dev_data <= 8'h00;
            bus.dev_data_oe <= 1'b0;
        end else begin
            bus.dev_data_oe <= !bus.rd_n; // RULE4
            if (!bus.rd_n) begin
                bus.dev_data <= byte_d; // RULE4
            end
        end
    end
endmodule

//--- src/hrp_pkg.sv
// constants and types shared by both ends of the host read port
// Operation
// (RULE1) host writes read code to address five
// (RULE2) read code captured on write strobe rise
// (RULE3) address lines pick byte within source
// (RULE4) device drives byte while read strobe low
// (RULE5) address seven returns status, ignoring code
// (RULE6) code zero: I and Q bytes
// (RULE7) code one: magnitude and phase bytes
// (RULE8) code two: frequency low, high bytes
// (RULE9) code four: 24-bit level detector bytes
// (RULE10) code five: gain mantissa and shift bytes
// (RULE11) host writes location ten to sample gain
// (RULE12) code five: unstabilised timing error bytes
// (RULE13) status bits six to four: FIFO depth
// (RULE14) status bit three: FIFO empty
// (RULE15) status bit two: FIFO full
// (RULE16) status bit one: active-low buffer ready
// (RULE17) status bit zero: level integration done
// (RULE18) host toggles read strobe per byte
// (RULE19) unused codes and addresses return zero
package hrp_pkg;

    // ----------------------------------------
    // port addresses
    // ----------------------------------------
    localparam logic [2:0] ADDR_READ_SOURCE_SELECT = 3'h5; // write: read code
    localparam logic [2:0] ADDR_STATUS_BYTE = 3'h7;        // read: status
    localparam logic [2:0] ADDR_GAIN_SAMPLE = 3'h2;        // location ten, binary 010

    // ----------------------------------------
    // read codes
    // ----------------------------------------
    localparam logic [2:0] CODE_IQ = 3'h0;
    localparam logic [2:0] CODE_MAG_PHASE = 3'h1;
    localparam logic [2:0] CODE_FREQ = 3'h2;
    localparam logic [2:0] CODE_LEVEL = 3'h4;
    localparam logic [2:0] CODE_GAIN_TE = 3'h5;
    localparam logic [2:0] CODE_RESET = 3'h0;              // read code after reset

    // ----------------------------------------
    // status field positions
    // ----------------------------------------
    localparam int STAT_DEPTH_LSB = 4;
    localparam int STAT_EMPTY_BIT = 3;
    localparam int STAT_FULL_BIT = 2;
    localparam int STAT_READY_N_BIT = 1;
    localparam int STAT_INTEG_BIT = 0;

    // ----------------------------------------
    // host controller register map (wishbone byte addresses)
    // ----------------------------------------
    localparam logic [7:0] WB_CTRL = 8'h00;    // wr: [2:0] addr,[10:8] data,[16] rd,[17] wr
    localparam logic [7:0] WB_STATUS = 8'h04;  // rd: [0] busy, [15:8] last read byte
    localparam logic [7:0] WB_IRQ_STAT = 8'h08; // [0] done, write one to clear
    localparam logic [7:0] WB_IRQ_MASK = 8'h0c; // [0] done enable

    // ----------------------------------------
    // host strobe timing, in clocks
    // ----------------------------------------
    localparam logic [3:0] STROBE_LOW_CYC = 4'h3;  // strobe low time
    localparam logic [3:0] STROBE_HIGH_CYC = 4'h2; // recovery high time

    // host sequencer states
    typedef enum logic [1:0] {
        HRP_IDLE = 2'b00,
        HRP_LOW = 2'b01,
        HRP_HIGH = 2'b10
    } hrp_state_t;

endpackage

//--- src/hrp_if.sv
// parallel host bus joining the controller and the read port
`timescale 1ns/1ns
interface hrp_if;
    logic [2:0] addr;       // byte address
    logic [7:0] host_data;  // host drive of data bus
    logic host_data_oe;     // host drives data bus
    logic [7:0] dev_data;   // device drive of data bus
    logic dev_data_oe;      // device drives data bus
    logic wr_n;             // write strobe, active low
    logic rd_n;             // read strobe, active low

    modport device (
        input addr, host_data, host_data_oe, wr_n, rd_n,
        output dev_data, dev_data_oe
    );
    modport host (
        input dev_data, dev_data_oe,
        output addr, host_data, host_data_oe, wr_n, rd_n
    );
endinterface

//--- src/hrp_host.sv
// host end: wishbone-controlled strobe sequencer for the read port
`timescale 1ns/1ns
module hrp_host (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // interrupt
    output logic irq_out,
    // host bus
    hrp_if.host bus
);
    hrp_pkg::hrp_state_t state_q;
    logic [3:0] cnt_q;
    logic is_rd_q;           // current strobe is a read
    logic [7:0] rd_byte_q;   // last byte read
    logic irq_stat_q;
    logic irq_mask_q;
    logic req;
    logic start;

    assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    // start a cycle only when idle; extra commands while busy are dropped
    assign start = req && wb_we_in && wb_adr_in == hrp_pkg::WB_CTRL && wb_sel_in[2]
                   && (wb_dat_in[16] || wb_dat_in[17]) && state_q == hrp_pkg::HRP_IDLE;

    // ----------------------------------------
    // wishbone ack and read data, one cycle answer
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h00000000;
        end else begin
            wb_ack_out <= req;
            if (req && !wb_we_in) begin
                case (wb_adr_in)
                    hrp_pkg::WB_STATUS:
                        wb_dat_out <= {16'h0000, rd_byte_q, 7'h00,
                                       state_q != hrp_pkg::HRP_IDLE};
                    hrp_pkg::WB_IRQ_STAT: wb_dat_out <= {31'h00000000, irq_stat_q};
                    hrp_pkg::WB_IRQ_MASK: wb_dat_out <= {31'h00000000, irq_mask_q};
                    default: wb_dat_out <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // strobe sequencer: low phase then forced high recovery
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state_q <= hrp_pkg::HRP_IDLE;
            cnt_q <= 4'h0;
            is_rd_q <= 1'b0;
            bus.addr <= 3'h0;
            bus.host_data <= 8'h00;
            bus.host_data_oe <= 1'b0;
            bus.wr_n <= 1'b1;
            bus.rd_n <= 1'b1;
        end else begin
            case (state_q)
                hrp_pkg::HRP_IDLE: begin
                    if (start) begin
                        is_rd_q <= wb_dat_in[16];
                        bus.addr <= wb_dat_in[2:0];
                        bus.host_data <= {5'h00, wb_dat_in[10:8]}; // RULE1
                        bus.host_data_oe <= !wb_dat_in[16];
                        bus.rd_n <= !wb_dat_in[16];
                        bus.wr_n <= wb_dat_in[16];
                        cnt_q <= hrp_pkg::STROBE_LOW_CYC;
                        state_q <= hrp_pkg::HRP_LOW;
                    end
                end
                hrp_pkg::HRP_LOW: begin
                    if (cnt_q == 4'h1) begin
                        bus.wr_n <= 1'b1; // RULE2
                        bus.rd_n <= 1'b1; // RULE18
                        cnt_q <= hrp_pkg::STROBE_HIGH_CYC;
                        state_q <= hrp_pkg::HRP_HIGH;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                hrp_pkg::HRP_HIGH: begin
                    // data held past the write strobe rise for hold time
                    if (cnt_q == 4'h1) begin
                        bus.host_data_oe <= 1'b0;
                        state_q <= hrp_pkg::HRP_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: state_q <= hrp_pkg::HRP_IDLE;
            endcase
        end
    end

    // byte taken in the last low cycle, device has driven it by then
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            rd_byte_q <= 8'h00;
        end else if (state_q == hrp_pkg::HRP_LOW && cnt_q == 4'h1 && is_rd_q) begin
            rd_byte_q <= bus.dev_data;
        end
    end

    // ----------------------------------------
    // interrupt: done sticky, set wins over clear
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            irq_stat_q <= 1'b0;
            irq_mask_q <= 1'b0;
        end else begin
            if (req && wb_we_in && wb_adr_in == hrp_pkg::WB_IRQ_MASK && wb_sel_in[0]) begin
                irq_mask_q <= wb_dat_in[0];
            end
            if (state_q == hrp_pkg::HRP_HIGH && cnt_q == 4'h1) begin
                irq_stat_q <= 1'b1;
            end else if (req && wb_we_in && wb_adr_in == hrp_pkg::WB_IRQ_STAT
                         && wb_sel_in[0] && wb_dat_in[0]) begin
                irq_stat_q <= 1'b0;
            end
        end
    end

    assign irq_out = irq_stat_q && irq_mask_q;
endmodule

//--- verif/hrp_assertions.sv
// concurrent checks on the parallel host bus between the two ends
`timescale 1ns/1ns
module hrp_assertions (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // host bus signals
    input wire logic [2:0] addr_in,
    input wire logic [7:0] host_data_in,
    input wire logic host_data_oe_in,
    input wire logic [7:0] dev_data_in,
    input wire logic dev_data_oe_in,
    input wire logic wr_n_in,
    input wire logic rd_n_in
);
    // ----------------------------------------
    // one clock domain, so one default clocking
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    // read strobe low exactly three cycles, one per byte
    property p_rd_width;
        $fell(rd_n_in) |-> !rd_n_in [*3] ##1 rd_n_in;
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("read strobe width wrong");

    // high recovery between bytes
    property p_rd_gap;
        $rose(rd_n_in) |-> rd_n_in [*2];
    endproperty
    a_rd_gap: assert property (p_rd_gap) else $error("read strobe recovery short");

    // byte address must not move while the strobe is low
    property p_addr_hold;
        !rd_n_in && !$past(rd_n_in) |-> $stable(addr_in);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in read");

    // device drives one clock after the strobe falls, for the whole low time
    property p_oe_on;
        $fell(rd_n_in) |=> dev_data_oe_in [*3];
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("device did not drive in read");

    // device lets go one clock after the strobe rises
    property p_oe_off;
        $rose(rd_n_in) |=> !dev_data_oe_in;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("device kept driving");

    // device output never turns on without a read behind it
    property p_oe_cause;
        $rose(dev_data_oe_in) |-> !$past(rd_n_in);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("device drove without read");

    // data held while the device releases the bus
    property p_data_hold;
        $fell(dev_data_oe_in) |-> $stable(dev_data_in);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("device data not held");

    // both ends never fight over the data bus
    property p_no_fight;
        !(host_data_oe_in && dev_data_oe_in);
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("data bus contention");

    // host write: data and address hold until the strobe rises
    property p_wr_hold;
        !wr_n_in && !$past(wr_n_in) |-> $stable(host_data_in) && $stable(addr_in)
            && host_data_oe_in;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write data moved");

    // the two strobes are never low together
    property p_strobe_excl;
        !(!rd_n_in && !wr_n_in);
    endproperty
    a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes low");
endmodule

//--- verif/tb.sv
// self-checking bench: host end drives device end over the parallel bus
`timescale 1ns/1ns
module tb;
    // ----------------------------------------
    // clock, reset, wishbone and sources
    // ----------------------------------------
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, r;
    logic ack, irq, gsmp;
    logic [15:0] i_v = 16'h1234, q_v = 16'h5678, mag_v = 16'h9abc, ph_v = 16'hdef0;
    logic [15:0] frq_v = 16'h2468, te_v = 16'h1357;
    logic [23:0] lvl_v = 24'h321af5;
    logic [14:0] gain_v = 15'h5a3c, gsnap;
    logic [2:0] dep_v = 3'h0;
    logic emp_v = 1'b0, ful_v = 1'b0, rdy_n_v = 1'b1, int_v = 1'b0;
    int failures = 0, total_checks = 0, pulses = 0;

    always #50 clk_sys_in = ~clk_sys_in;
    // count gain sample pulses seen at the device
    always @(posedge clk_sys_in) if (gsmp === 1'b1) pulses <= pulses + 1;

    hrp_if i_hrp_if ();
    hrp_host i_hrp_host (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq), .bus(i_hrp_if));
    hrp_device i_hrp_device (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .bus(i_hrp_if),
        .i_in(i_v), .q_in(q_v), .mag_in(mag_v), .phase_in(ph_v), .freq_in(frq_v),
        .level_in(lvl_v), .gain_in(gain_v), .timing_err_in(te_v), .fifo_depth_in(dep_v),
        .fifo_empty_in(emp_v), .fifo_full_in(ful_v), .buffer_ready_n_in(rdy_n_v),
        .integ_done_in(int_v), .gain_sample_out(gsmp));
    hrp_assertions i_hrp_assertions (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .addr_in(i_hrp_if.addr), .host_data_in(i_hrp_if.host_data),
        .host_data_oe_in(i_hrp_if.host_data_oe), .dev_data_in(i_hrp_if.dev_data),
        .dev_data_oe_in(i_hrp_if.dev_data_oe), .wr_n_in(i_hrp_if.wr_n),
        .rd_n_in(i_hrp_if.rd_n));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // classic single wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge clk_sys_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            failures++;
            stop_test();
        end
    endtask

    // one host bus transfer, then poll busy; returns the byte read
    task automatic hop(input logic [31:0] ctl, output logic [7:0] b);
        int n;
        wb(1'b1, hrp_pkg::WB_CTRL, ctl, r);
        n = 0;
        do begin
            wb(1'b0, hrp_pkg::WB_STATUS, 32'h0, r);
            n++;
        end while (r[0] !== 1'b0 && n < 20);
        if (r[0] !== 1'b0) begin
            failures++;
            stop_test();
        end
        b = r[15:8];
    endtask

    function automatic logic [31:0] rdc(input logic [2:0] a);
        return {14'h0, 2'h1, 5'h0, 3'h0, 5'h0, a};
    endfunction
    function automatic logic [31:0] wrc(input logic [2:0] a, input logic [2:0] d);
        return {14'h0, 2'h2, 5'h0, d, 5'h0, a};
    endfunction
    function automatic logic [7:0] pick(input logic [31:0] v, input logic [2:0] a, input int n);
        return (a < n) ? v[a * 8 +: 8] : 8'h00;
    endfunction
    // byte the device should return for a read code and address
    function automatic logic [7:0] expb(input logic [2:0] c, input logic [2:0] a);
        if (a == 3'h7) return {1'b0, dep_v, emp_v, ful_v, rdy_n_v, int_v};
        case (c)
            hrp_pkg::CODE_IQ: return pick({q_v, i_v}, a, 4);
            hrp_pkg::CODE_MAG_PHASE: return pick({ph_v, mag_v}, a, 4);
            hrp_pkg::CODE_FREQ: return pick({16'h0, frq_v}, a, 2);
            hrp_pkg::CODE_LEVEL: return pick({8'h0, lvl_v}, a, 3);
            hrp_pkg::CODE_GAIN_TE: return pick({te_v, 1'b0, gsnap}, a, 4);
            default: return 8'h00;
        endcase
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [7:0] b;
        @(posedge clk_sys_in);
        chk("irq after reset", {31'h0, irq}, 32'h0);
        wb(1'b0, hrp_pkg::WB_IRQ_MASK, 32'h0, r);
        chk("mask after reset", r, 32'h0);
        hop(rdc(3'h0), b);
        chk("default code byte", {24'h0, b}, {24'h0, i_v[7:0]});
        $display("reset test done");
    endtask

    // every code against every address, status at address seven
    task automatic t_codes();
        logic [7:0] b;
        int p0;
        p0 = pulses;
        hop(wrc(hrp_pkg::ADDR_GAIN_SAMPLE, 3'h0), b);
        gsnap = gain_v;
        chk("gain pulses", pulses, p0 + 1);
        for (int c = 0; c < 8; c++) begin
            hop(wrc(hrp_pkg::ADDR_READ_SOURCE_SELECT, c[2:0]), b);
            for (int a = 0; a < 8; a++) begin
                hop(rdc(a[2:0]), b);
                chk("byte", {24'h0, b}, {24'h0, expb(c[2:0], a[2:0])});
            end
        end
        $display("code table test done");
    endtask

    // gain bytes stay frozen until sampled again
    task automatic t_gain();
        logic [7:0] b;
        int p0;
        hop(wrc(hrp_pkg::ADDR_READ_SOURCE_SELECT, hrp_pkg::CODE_GAIN_TE), b);
        @(posedge clk_sys_in);
        gain_v <= 15'h2bd1;
        hop(rdc(3'h1), b);
        chk("gain held", {24'h0, b}, {24'h0, 1'b0, gsnap[14:8]});
        hop(wrc(hrp_pkg::ADDR_GAIN_SAMPLE, 3'h0), b);
        hop(rdc(3'h0), b);
        chk("gain resampled", {24'h0, b}, {24'h0, 8'hd1});
        // a command issued while busy is acked but dropped, so no sample pulse
        p0 = pulses;
        wb(1'b1, hrp_pkg::WB_CTRL, rdc(3'h0), r);
        hop(wrc(hrp_pkg::ADDR_GAIN_SAMPLE, 3'h0), b);
        // read and write bits together: the read wins, no write strobe
        hop(rdc(hrp_pkg::ADDR_GAIN_SAMPLE) | wrc(3'h0, 3'h0), b);
        chk("read wins", {24'h0, b}, {24'h0, te_v[7:0]});
        chk("no sample pulse", pulses, p0);
        $display("gain test done");
    endtask

    // status patterns read under an unused code
    task automatic t_status();
        logic [7:0] b;
        hop(wrc(hrp_pkg::ADDR_READ_SOURCE_SELECT, 3'h3), b);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys_in);
            dep_v <= 3'(k * 3);
            emp_v <= k[0];
            ful_v <= k[1];
            rdy_n_v <= ~k[0];
            int_v <= k[1] ^ k[0];
            hop(rdc(3'h7), b);
            chk("status", {24'h0, b}, {24'h0, expb(3'h3, 3'h7)});
        end
        $display("status test done");
    endtask

    // done interrupt: masked, unmasked, cleared; unmapped read
    task automatic t_irq();
        logic [7:0] b;
        wb(1'b1, hrp_pkg::WB_IRQ_STAT, 32'h1, r);
        hop(rdc(3'h0), b);
        wb(1'b0, hrp_pkg::WB_IRQ_STAT, 32'h0, r);
        chk("irq status", r, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wb(1'b1, hrp_pkg::WB_IRQ_MASK, 32'h1, r);
        wb(1'b0, hrp_pkg::WB_IRQ_MASK, 32'h0, r);
        chk("mask set", r, 32'h1);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        wb(1'b1, hrp_pkg::WB_IRQ_STAT, 32'h1, r);
        wb(1'b0, hrp_pkg::WB_IRQ_STAT, 32'h0, r);
        chk("irq cleared", r, 32'h0);
        chk("irq line low", {31'h0, irq}, 32'h0);
        wb(1'b0, 8'h10, 32'h0, r);
        chk("unmapped read", r, 32'h0);
        $display("interrupt test done");
    endtask

    initial begin
        repeat (6) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        t_reset();
        t_codes();
        t_gain();
        t_status();
        t_irq();
        stop_test();
    end
endmodule
